// ---- btc_term_ctrl.sv ----
// transaction termination controller of a three-port bridge
`timescale 1ns/1ps
`include "btc_defs.svh"
// --------------------------------------------------------------
// --------------------------------------------------------------
module btc_term_ctrl
	import btc_pkg::*;
#(
	parameter logic [31:0] ATTEMPT_LIMIT = `BTC_ATT_LIMIT,
	parameter logic [31:0] DISCARD_CYCLES = `BTC_DISCARD_CYC
)
(
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	input wire logic XFER_VALID,
	input wire logic [1:0] XFER_KIND,
	input wire logic [31:0] XFER_ADDR,
	input wire logic [3:0] XFER_CMD,
	input wire logic [7:0] XFER_DWORDS,
	input wire logic XFER_PREF,
	input wire logic [1:0] XFER_DST,
	input wire logic [1:0] XFER_SRC,
	output logic XFER_TAKEN,
	output logic BUS_FRAME,
	output logic [31:0] BUS_ADDR,
	output logic [3:0] BUS_CMD,
	output logic [1:0] BUS_PORT,
	input wire logic BUS_DEVSEL,
	input wire logic BUS_TRDY,
	input wire logic BUS_STOP,
	output logic UPSTREAM_FREE,
	output logic UPSTREAM_SYSTEM_ERROR_N,
	output logic DR_READY,
	output logic [7:0] DR_FETCHED,
	input wire logic TS_REQ,
	input wire logic [1:0] TS_KIND,
	input wire logic TS_LOCKED,
	input wire logic TS_MATCH,
	input wire logic [7:0] TS_WANTED,
	input wire logic TS_ENQUEUING,
	input wire logic TS_QUEUE_FULL,
	input wire logic TS_DUP,
	input wire logic TS_NOT_HEAD,
	input wire logic TS_POSTED_AHEAD,
	input wire logic TS_DISCARDING,
	input wire logic TS_BUF_ROOM,
	input wire logic TS_BOUNDARY,
	input wire logic TS_WBUF_FULL,
	input wire logic TS_ACCEPTING,
	input wire logic LOCK_ACTIVE,
	input wire logic TGT_BUS_LOCKED,
	output logic TS_RETRY,
	output logic TS_DISCONNECT,
	output logic TS_ABORT,
	output logic TS_NO_DEVSEL
);
	// --------------------------------------------------------------
	// registers and state
	// --------------------------------------------------------------
	logic [31:0] cmd_q; // command, serr enable
	logic [31:0] evdis_q; // event disable bits
	logic [`BTC_STAT_W-1:0] stat_q; // sticky status
	logic [`BTC_STAT_W-1:0] stat_set; // hardware set terms
	logic [31:0] rdata_q; // read answer
	btc_state_e state_q; // sequencer state
	btc_kind_e kind_q; // kind in flight
	btc_term_e term_q; // how the attempt ended
	logic [31:0] addr_q; // current dword address
	logic [3:0] bcmd_q; // command on the target bus
	logic [7:0] rem_q; // dwords still to deliver
	logic [7:0] got_q; // dwords moved so far
	logic pref_q; // prefetchable read
	logic [1:0] port_q; // target port
	logic frame_q; // frame driven
	logic seen_q; // device select seen this attempt
	logic moved_q; // data moved this attempt
	logic [2:0] wait_q; // cycles without device select
	logic [31:0] att_q; // attempt counter
	logic taken_q; // head consumed pulse
	logic upfree_q; // upstream left idle
	logic serr_n_q; // system error output
	logic dr_ready_q; // delayed result stored
	btc_term_e dr_term_q; // stored delayed outcome
	logic [7:0] dr_fetch_q; // stored dword count
	logic dr_pref_q; // stored prefetch flag
	logic [31:0] dr_age_q; // age of stored result
	logic [4:0] acc_q; // acceptance cycle count
	logic retry_q; // target side retry
	logic disc_q; // target side disconnect
	logic abort_q; // target side abort
	logic nodev_q; // reflect master abort
	// --------------------------------------------------------------
	// register decode
	// --------------------------------------------------------------
	wire wr_cmd = REG_WR && (REG_ADDR == `BTC_OFF_CMD);
	wire wr_stat = REG_WR && (REG_ADDR == `BTC_OFF_STAT);
	wire wr_evdis = REG_WR && (REG_ADDR == `BTC_OFF_EVDIS);
	wire serr_en = cmd_q[`BTC_CMD_SERR_EN];
	// unmapped offsets read as zero
	wire [31:0] rd_mux = (REG_ADDR == `BTC_OFF_CMD) ? cmd_q :
		(REG_ADDR == `BTC_OFF_STAT) ? {28'h0000000, stat_q} :
		(REG_ADDR == `BTC_OFF_EVDIS) ? evdis_q : 32'h0000_0000;
	// --------------------------------------------------------------
	// initiator side decode
	// --------------------------------------------------------------
	wire in_bus = (state_q == S_BUS);
	wire in_gap = (state_q == S_GAP);
	wire dx = in_bus && BUS_DEVSEL && BUS_TRDY; // dword moved
	wire last_dx = dx && (rem_q == 8'h01);
	wire ma_hit = in_bus && !seen_q && !BUS_DEVSEL && (wait_q == 3'(`BTC_MA_CYC - 1));
	wire ta_hit = in_bus && BUS_STOP && !BUS_DEVSEL && !BUS_TRDY && seen_q;
	wire stop_dev = in_bus && BUS_STOP && BUS_DEVSEL;
	// retry only when nothing moved in the attempt
	wire rty_hit = stop_dev && !BUS_TRDY && !moved_q;
	wire dsc_hit = stop_dev && !rty_hit;
	wire end_hit = ma_hit || ta_hit || stop_dev || last_dx;
	wire pw = (kind_q == K_PW);
	wire left = (rem_q != 8'h00);
	wire lim_hit = (att_q + 32'h1) >= ATTEMPT_LIMIT;
	wire again = in_gap && !lim_hit &&
		(term_q == T_RETRY || (term_q == T_DISC && pw && left));
	wire give_up = in_gap && lim_hit &&
		(term_q == T_RETRY || (term_q == T_DISC && pw && left));
	wire nd_dis = pw ? evdis_q[`BTC_EVDIS_PW_ND] : evdis_q[`BTC_EVDIS_DR_ND];
	wire serr_nd = give_up && serr_en && !nd_dis;
	wire serr_ta = in_gap && (term_q == T_ABORT) && pw && serr_en;
	wire serr_ev = serr_nd || serr_ta;
	// a delayed read waits until its old result is answered or discarded
	wire start = (state_q == S_IDLE) && XFER_VALID &&
		!(XFER_KIND != 2'(K_PW) && dr_ready_q);
	wire dr_done = in_gap && (kind_q != K_PW) && !again && !give_up;
	// --------------------------------------------------------------
	// target side decode
	// --------------------------------------------------------------
	wire ts_pw = (TS_KIND == 2'(K_PW));
	wire ts_dr = (TS_KIND == 2'(K_DR));
	wire ts_dly = !ts_pw;
	wire lock_rty = (LOCK_ACTIVE && !TS_LOCKED) || (TGT_BUS_LOCKED && TS_LOCKED);
	wire slow_rty = ts_dly && (acc_q > 5'(`BTC_ACC_MAX));
	wire dly_rty = ts_dly && (TS_ENQUEUING || TS_QUEUE_FULL || TS_DUP ||
		TS_NOT_HEAD || !TS_MATCH || !dr_ready_q);
	wire rd_rty = ts_dr && (TS_POSTED_AHEAD || TS_DISCARDING);
	// no room for address plus a dword
	wire pw_rty = ts_pw && !TS_BUF_ROOM;
	wire ts_rty = lock_rty || slow_rty || dly_rty || rd_rty || pw_rty;
	wire ts_hit = TS_REQ && !ts_rty && ts_dly; // stored result answered
	wire more = TS_WANTED > dr_fetch_q;
	wire nrm_dsc = (dr_term_q == T_NORMAL) && (!dr_pref_q || more);
	wire dsc_dsc = (dr_term_q == T_DISC) && more;
	wire own_dsc = TS_BOUNDARY || (!ts_dr && TS_WBUF_FULL);
	wire ts_dsc = TS_REQ && !ts_rty &&
		(own_dsc || (ts_hit && (nrm_dsc || dsc_dsc)));
	wire ts_ab = ts_hit && (dr_term_q == T_ABORT);
	wire ts_nd = ts_hit && (dr_term_q == T_MA);
	wire aged = dr_ready_q && (dr_age_q >= DISCARD_CYCLES);
	// --------------------------------------------------------------
	// status set terms
	// --------------------------------------------------------------
	always_comb
	begin
		stat_set = '0;
		stat_set[`BTC_ST_RX_TA] = in_gap && (term_q == T_ABORT);
		stat_set[`BTC_ST_SIG_TA] = ts_ab;
		stat_set[`BTC_ST_SIG_SE] = serr_ev;
		stat_set[`BTC_ST_RX_MA] = in_gap && (term_q == T_MA);
	end
	// --------------------------------------------------------------
	// register file, set wins over clear
	// --------------------------------------------------------------
	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			cmd_q <= `BTC_CMD_RST;
			evdis_q <= `BTC_EVDIS_RST;
			stat_q <= `BTC_STAT_RST;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			if (wr_cmd)
				cmd_q <= REG_WDATA;
			if (wr_evdis)
				evdis_q <= REG_WDATA;
			// write one to clear, hardware set wins
			stat_q <= (stat_q & ~(wr_stat ? REG_WDATA[`BTC_STAT_W-1:0] : '0)) | stat_set;
			// data valid only in the cycle after the strobe
			rdata_q <= REG_RD ? rd_mux : 32'h0000_0000;
		end
	end
	// --------------------------------------------------------------
	// initiator sequencer
	// --------------------------------------------------------------
	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			state_q <= S_IDLE;
			kind_q <= K_PW;
			term_q <= T_NONE;
			frame_q <= 1'b0;
			seen_q <= 1'b0;
			moved_q <= 1'b0;
			wait_q <= 3'h0;
			taken_q <= 1'b0;
		end
		else
		begin
			taken_q <= start;
			case (state_q)
				S_IDLE:
				begin
					if (start)
					begin
						kind_q <= btc_kind_e'(XFER_KIND);
						state_q <= S_BUS;
						frame_q <= 1'b1;
						seen_q <= 1'b0;
						moved_q <= 1'b0;
						wait_q <= 3'h0;
					end
				end
				S_BUS:
				begin
					if (BUS_DEVSEL)
						seen_q <= 1'b1;
					else if (!seen_q)
						wait_q <= wait_q + 3'h1;
					if (dx)
						moved_q <= 1'b1;
					if (end_hit)
					begin
						frame_q <= 1'b0;
						state_q <= S_GAP;
						// outcome, priority abort forms first
						if (ma_hit)
							term_q <= T_MA;
						else if (ta_hit)
							term_q <= T_ABORT;
						else if (rty_hit)
							term_q <= T_RETRY;
						else if (dsc_hit)
							term_q <= T_DISC;
						else
							term_q <= T_NORMAL;
					end
				end
				S_GAP:
				begin
					if (again)
					begin
						state_q <= S_BUS;
						frame_q <= 1'b1;
						seen_q <= 1'b0;
						moved_q <= 1'b0;
						wait_q <= 3'h0;
					end
					else
						state_q <= S_IDLE;
				end
				default:
					state_q <= S_IDLE;
			endcase
		end
	end
	// --------------------------------------------------------------
	// address, command and counters of the attempt
	// --------------------------------------------------------------
	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			addr_q <= 32'h0000_0000;
			bcmd_q <= 4'h0;
			rem_q <= 8'h00;
			got_q <= 8'h00;
			pref_q <= 1'b0;
			port_q <= 2'h0;
			att_q <= 32'h0000_0000;
			upfree_q <= 1'b1;
		end
		else if (start)
		begin
			addr_q <= XFER_ADDR;
			bcmd_q <= XFER_CMD;
			// non-prefetchable reads fetch a single dword
			rem_q <= (XFER_KIND != 2'(K_PW) && !XFER_PREF) ? 8'h01 : XFER_DWORDS;
			got_q <= 8'h00;
			pref_q <= XFER_PREF;
			port_q <= XFER_DST;
			att_q <= 32'h0000_0000;
			upfree_q <= (XFER_DST != 2'h0) && (XFER_SRC != 2'h0);
		end
		else
		begin
			if (dx)
			begin
				addr_q <= addr_q + 32'h4;
				rem_q <= rem_q - 8'h01;
				got_q <= got_q + 8'h01;
			end
			if (again)
				att_q <= att_q + 32'h1;
			// broken cache line goes as plain write
			if (again && term_q == T_DISC && bcmd_q == `BTC_CMD_MWI)
				bcmd_q <= `BTC_CMD_MW;
			if (in_gap && !again)
				att_q <= 32'h0000_0000;
			if (state_q == S_IDLE)
				upfree_q <= 1'b1;
		end
	end
	// --------------------------------------------------------------
	// system error pulse
	// --------------------------------------------------------------
	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
			serr_n_q <= 1'b1;
		else
			serr_n_q <= !serr_ev;
	end
	// --------------------------------------------------------------
	// delayed result store
	// --------------------------------------------------------------
	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			dr_ready_q <= 1'b0;
			dr_term_q <= T_NONE;
			dr_fetch_q <= 8'h00;
			dr_pref_q <= 1'b0;
			dr_age_q <= 32'h0000_0000;
		end
		else if (dr_done)
		begin
			// stop once data, abort or master abort
			dr_ready_q <= 1'b1;
			dr_term_q <= term_q;
			dr_fetch_q <= got_q;
			dr_pref_q <= pref_q;
			dr_age_q <= 32'h0000_0000;
		end
		else if (ts_hit || aged)
		begin
			// answered or timed out, entry freed
			dr_ready_q <= 1'b0;
			dr_age_q <= 32'h0000_0000;
		end
		else if (dr_ready_q)
			dr_age_q <= dr_age_q + 32'h1;
	end
	// --------------------------------------------------------------
	// target side answers
	// --------------------------------------------------------------
	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			acc_q <= 5'h00;
			retry_q <= 1'b0;
			disc_q <= 1'b0;
			abort_q <= 1'b0;
			nodev_q <= 1'b0;
		end
		else
		begin
			// saturating count of acceptance cycles
			if (!TS_ACCEPTING)
				acc_q <= 5'h00;
			else if (acc_q != 5'h1F)
				acc_q <= acc_q + 5'h01;
			retry_q <= TS_REQ && ts_rty;
			disc_q <= ts_dsc;
			abort_q <= ts_ab;
			nodev_q <= ts_nd;
		end
	end
	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	assign REG_RDATA = rdata_q;
	assign XFER_TAKEN = taken_q;
	assign BUS_FRAME = frame_q;
	assign BUS_ADDR = addr_q;
	assign BUS_CMD = bcmd_q;
	assign BUS_PORT = port_q;
	assign UPSTREAM_FREE = upfree_q;
	assign UPSTREAM_SYSTEM_ERROR_N = serr_n_q;
	assign DR_READY = dr_ready_q;
	assign DR_FETCHED = dr_fetch_q;
	assign TS_RETRY = retry_q;
	assign TS_DISCONNECT = disc_q;
	assign TS_ABORT = abort_q;
	assign TS_NO_DEVSEL = nodev_q;
	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	property p_ma;
		@(posedge CORE_CLK) disable iff (RST)
		BUS_FRAME && !BUS_DEVSEL && !BUS_STOP ##1 (BUS_FRAME && !seen_q && !BUS_DEVSEL)[*4] |=> !BUS_FRAME;
	endproperty
	a_ma: assert property (p_ma) else $error("no master abort after five cycles");
	property p_rty_addr;
		@(posedge CORE_CLK) disable iff (RST)
		in_gap && again && term_q == T_RETRY |=> BUS_FRAME && BUS_ADDR == $past(BUS_ADDR, 2);
	endproperty
	a_rty_addr: assert property (p_rty_addr) else $error("retry changed the address");
	property p_dsc_addr;
		@(posedge CORE_CLK) disable iff (RST)
		dx |=> BUS_ADDR == $past(BUS_ADDR) + 32'h4;
	endproperty
	a_dsc_addr: assert property (p_dsc_addr) else $error("address not advanced");
	property p_mwi;
		@(posedge CORE_CLK) disable iff (RST)
		again && term_q == T_DISC && BUS_CMD == `BTC_CMD_MWI |=> BUS_CMD == `BTC_CMD_MW ##1 BUS_FRAME;
	endproperty
	a_mwi: assert property (p_mwi) else $error("invalidate command kept");
	property p_pw_ta;
		@(posedge CORE_CLK) disable iff (RST)
		in_gap && term_q == T_ABORT && pw && serr_en |=> !UPSTREAM_SYSTEM_ERROR_N && stat_q[`BTC_ST_SIG_SE];
	endproperty
	a_pw_ta: assert property (p_pw_ta) else $error("posted abort not reported");
	property p_nd;
		@(posedge CORE_CLK) disable iff (RST)
		give_up && serr_en && !nd_dis |=> !UPSTREAM_SYSTEM_ERROR_N ##1 UPSTREAM_SYSTEM_ERROR_N;
	endproperty
	a_nd: assert property (p_nd) else $error("non-delivery error missing");
	property p_lock;
		@(posedge CORE_CLK) disable iff (RST)
		TS_REQ && LOCK_ACTIVE && !TS_LOCKED |=> TS_RETRY && !TS_DISCONNECT && !TS_ABORT;
	endproperty
	a_lock: assert property (p_lock) else $error("unlocked access not retried");
	property p_slow;
		@(posedge CORE_CLK) disable iff (RST)
		TS_REQ && !ts_pw && acc_q > 5'(`BTC_ACC_MAX) |=> TS_RETRY;
	endproperty
	a_slow: assert property (p_slow) else $error("slow acceptance not retried");
	property p_ta_flag;
		@(posedge CORE_CLK) disable iff (RST)
		TS_ABORT |-> stat_q[`BTC_ST_SIG_TA] && !DR_READY && !TS_RETRY;
	endproperty
	a_ta_flag: assert property (p_ta_flag) else $error("abort without signaled flag");
	property p_att;
		@(posedge CORE_CLK) disable iff (RST)
		start |=> att_q == 32'h0000_0000;
	endproperty
	a_att: assert property (p_att) else $error("attempt count not cleared");
	c_retry: cover property (@(posedge CORE_CLK) disable iff (RST) again && term_q == T_RETRY);
	c_disc: cover property (@(posedge CORE_CLK) disable iff (RST) again && term_q == T_DISC);
	c_abort: cover property (@(posedge CORE_CLK) disable iff (RST) TS_ABORT);
	c_rd: cover property (@(posedge CORE_CLK) disable iff (RST) dr_done ##[1:20] TS_DISCONNECT);
endmodule // btc_term_ctrl

// ---- btc_defs.svh ----
// constants for the bridge termination controller
`ifndef BTC_DEFS_SVH
`define BTC_DEFS_SVH
// --------------------------------------------------------------
// register byte offsets
// --------------------------------------------------------------
`define BTC_OFF_CMD 8'h04
`define BTC_OFF_STAT 8'h08
`define BTC_OFF_EVDIS 8'h64
// --------------------------------------------------------------
// field positions
// --------------------------------------------------------------
`define BTC_CMD_SERR_EN 8
`define BTC_EVDIS_PW_ND 2
`define BTC_EVDIS_DR_ND 5
`define BTC_ST_RX_TA 0
`define BTC_ST_SIG_TA 1
`define BTC_ST_SIG_SE 2
`define BTC_ST_RX_MA 3
`define BTC_STAT_W 4
// --------------------------------------------------------------
// reset values
// --------------------------------------------------------------
`define BTC_CMD_RST 32'h0000_0000
`define BTC_EVDIS_RST 32'h0000_0000
`define BTC_STAT_RST 4'h0
// --------------------------------------------------------------
// bus commands and timing counts
// --------------------------------------------------------------
`define BTC_CMD_MW 4'h7
`define BTC_CMD_MWI 4'hF
`define BTC_MA_CYC 5
`define BTC_ACC_MAX 16
`define BTC_ATT_LIMIT 32'h0100_0000
`define BTC_DISCARD_CYC 32'h0000_8000
`endif

// ---- btc_pkg.sv ----
// types shared by the bridge termination controller
package btc_pkg;
	// transaction kinds carried by the queues
	typedef enum logic [1:0] {K_PW, K_DR, K_DW} btc_kind_e;
	// initiator sequencer states
	typedef enum logic [1:0] {S_IDLE, S_BUS, S_GAP} btc_state_e;
	// how the target ended an attempt
	typedef enum logic [2:0] {T_NONE, T_NORMAL, T_RETRY, T_DISC, T_ABORT, T_MA} btc_term_e;
endpackage

// ---- btc_target_model.sv ----
// behavioural pci target facing the bridge initiator
`timescale 1ns/1ps
// --------------------------------------------------------------
// target model
// --------------------------------------------------------------
module btc_target_model
(
	input wire logic clk,
	input wire logic rst,
	input wire logic frame,
	input wire logic [1:0] mode,
	input wire logic [7:0] retries,
	output logic devsel,
	output logic trdy,
	output logic stop
);
	logic [7:0] n_q; // cycle within an attempt
	logic [7:0] att_q; // attempts seen since reset
	// answers trail frame by one cycle; all lines fall back to idle once frame drops
	always_ff @(posedge clk)
	begin
		n_q <= n_q + 8'h01;
		if (rst || !frame)
		begin
			{devsel, trdy, stop} <= 3'h0;
			n_q <= 8'h00;
		end
		// retry quota is spent before the mode applies
		else if (n_q == 8'h00 && att_q < retries)
			{devsel, trdy, stop} <= 3'h5;
		else
			case (mode)
				2'h0: {devsel, trdy, stop} <= 3'h6; // data every cycle
				2'h1: {devsel, trdy, stop} <= (n_q == 8'h00) ? 3'h6 : 3'h5; // one dword, then stop
				2'h2: {devsel, trdy, stop} <= (n_q == 8'h00) ? 3'h4 : 3'h1; // select first, then abort
				default: {devsel, trdy, stop} <= 3'h0; // nobody answers
			endcase
		// count attempts only at their first cycle
		if (rst)
			att_q <= 8'h00;
		else if (frame && n_q == 8'h00)
			att_q <= att_q + 8'h01;
	end
endmodule // btc_target_model

// ---- btc_term_ctrl_tb.sv ----
// self-checking bench for the bridge termination controller
`timescale 1ns/1ps
`include "btc_defs.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
	$display("Error %s expected %0h seen %0h", n, e, g); end end
// --------------------------------------------------------------
// bench top
// --------------------------------------------------------------
module btc_term_ctrl_tb
	import btc_pkg::*;
;
	logic CORE_CLK = 1'b0, RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, XFER_VALID = 1'b0, XFER_PREF = 1'b0;
	logic [7:0] REG_ADDR = 8'h00, XFER_DWORDS = 8'h00, TS_WANTED = 8'h00, retries = 8'h00, DR_FETCHED;
	logic [31:0] REG_WDATA = 32'h0, XFER_ADDR = 32'h0, REG_RDATA, BUS_ADDR;
	logic [1:0] XFER_KIND = 2'h0, XFER_DST = 2'h0, XFER_SRC = 2'h0, TS_KIND = 2'h0, mode = 2'h0, BUS_PORT;
	logic [3:0] XFER_CMD = 4'h0, BUS_CMD;
	logic TS_REQ = 1'b0, TS_LOCKED = 1'b0, TS_MATCH = 1'b0, TS_ENQUEUING = 1'b0, TS_QUEUE_FULL = 1'b0;
	logic TS_DUP = 1'b0, TS_NOT_HEAD = 1'b0, TS_POSTED_AHEAD = 1'b0, TS_DISCARDING = 1'b0, TS_BUF_ROOM = 1'b0;
	logic TS_BOUNDARY = 1'b0, TS_WBUF_FULL = 1'b0, LOCK_ACTIVE = 1'b0, TGT_BUS_LOCKED = 1'b0;
	logic TS_ACCEPTING = 1'b0; // held high to stretch an acceptance
	logic XFER_TAKEN, BUS_FRAME, BUS_DEVSEL, BUS_TRDY, BUS_STOP, UPSTREAM_FREE, UPSTREAM_SYSTEM_ERROR_N, DR_READY;
	logic TS_RETRY, TS_DISCONNECT, TS_ABORT, TS_NO_DEVSEL, fr_q;
	logic [31:0] aq[$]; // address at each attempt start
	logic [3:0] cq[$]; // command at each attempt start
	logic fq[$]; // upstream-free at each attempt start
	int sc, fail_count, compares, r;
	// target-side cases: {kind,locked,enq,full,dup,nothead,postahead,discard,room,bound,wfull,lock,tlock}, answer
	logic [17:0] tsr [13] = '{{14'h2400, 4'h8}, {14'h2200, 4'h8}, {14'h2100, 4'h8}, {14'h1080, 4'h8},
		{14'h1040, 4'h8}, {14'h1020, 4'h8}, {14'h0012, 4'h8}, {14'h0813, 4'h8}, {14'h0000, 4'h8},
		{14'h0018, 4'h4}, {14'h0014, 4'h4}, {14'h0010, 4'h0}, {14'h0812, 4'h0}};
	// delayed reads: {pref, dwords, mode, wanted, fetched, answer, status}
	logic [34:0] drt [5] = '{{1'h0, 8'h01, 2'h0, 8'h02, 8'h01, 4'h4, 4'h0}, {1'h1, 8'h04, 2'h0, 8'h04, 8'h04, 4'h0, 4'h0},
		{1'h1, 8'h04, 2'h1, 8'h02, 8'h01, 4'h4, 4'h0}, {1'h0, 8'h01, 2'h2, 8'h01, 8'h00, 4'h2, 4'h3},
		{1'h0, 8'h01, 2'h3, 8'h01, 8'h00, 4'h1, 4'h8}};
	always #20 CORE_CLK = ~CORE_CLK;
	// short counts so limits are reached quickly
	btc_term_ctrl #(.ATTEMPT_LIMIT(32'h4), .DISCARD_CYCLES(32'h40)) uut (.CORE_CLK(CORE_CLK), .RST(RST),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.XFER_VALID(XFER_VALID), .XFER_KIND(XFER_KIND), .XFER_ADDR(XFER_ADDR), .XFER_CMD(XFER_CMD),
		.XFER_DWORDS(XFER_DWORDS), .XFER_PREF(XFER_PREF), .XFER_DST(XFER_DST), .XFER_SRC(XFER_SRC),
		.XFER_TAKEN(XFER_TAKEN), .BUS_FRAME(BUS_FRAME), .BUS_ADDR(BUS_ADDR), .BUS_CMD(BUS_CMD), .BUS_PORT(BUS_PORT),
		.BUS_DEVSEL(BUS_DEVSEL), .BUS_TRDY(BUS_TRDY), .BUS_STOP(BUS_STOP), .UPSTREAM_FREE(UPSTREAM_FREE),
		.UPSTREAM_SYSTEM_ERROR_N(UPSTREAM_SYSTEM_ERROR_N), .DR_READY(DR_READY), .DR_FETCHED(DR_FETCHED),
		.TS_REQ(TS_REQ), .TS_KIND(TS_KIND), .TS_LOCKED(TS_LOCKED), .TS_MATCH(TS_MATCH), .TS_WANTED(TS_WANTED),
		.TS_ENQUEUING(TS_ENQUEUING), .TS_QUEUE_FULL(TS_QUEUE_FULL), .TS_DUP(TS_DUP), .TS_NOT_HEAD(TS_NOT_HEAD),
		.TS_POSTED_AHEAD(TS_POSTED_AHEAD), .TS_DISCARDING(TS_DISCARDING), .TS_BUF_ROOM(TS_BUF_ROOM),
		.TS_BOUNDARY(TS_BOUNDARY), .TS_WBUF_FULL(TS_WBUF_FULL), .TS_ACCEPTING(TS_ACCEPTING),
		.LOCK_ACTIVE(LOCK_ACTIVE), .TGT_BUS_LOCKED(TGT_BUS_LOCKED), .TS_RETRY(TS_RETRY),
		.TS_DISCONNECT(TS_DISCONNECT), .TS_ABORT(TS_ABORT), .TS_NO_DEVSEL(TS_NO_DEVSEL));
	btc_target_model tgt (.clk(CORE_CLK), .rst(RST), .frame(BUS_FRAME), .mode(mode), .retries(retries),
		.devsel(BUS_DEVSEL), .trdy(BUS_TRDY), .stop(BUS_STOP));
	// log every attempt start and count error pulses
	always @(posedge CORE_CLK)
	begin
		fr_q <= BUS_FRAME;
		if (BUS_FRAME === 1'b1 && fr_q !== 1'b1)
		begin
			aq.push_back(BUS_ADDR);
			cq.push_back(BUS_CMD);
			fq.push_back(UPSTREAM_FREE);
		end
		if (UPSTREAM_SYSTEM_ERROR_N === 1'b0)
			sc++;
	end
	task automatic report_and_stop;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// a spent bound is a mismatch and ends the run
	task automatic hang;
		fail_count++;
		report_and_stop();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CORE_CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CORE_CLK);
		REG_WR <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge CORE_CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CORE_CLK);
		REG_RD <= 1'b0;
		#1;
		`CHK("rdata", e, REG_RDATA)
	endtask
	// reset, clear the logs, optionally enable the error output
	task automatic rst(input int n, input logic en);
		RST <= 1'b1;
		repeat (n) @(posedge CORE_CLK);
		RST <= 1'b0;
		aq.delete();
		cq.delete();
		fq.delete();
		sc = 0;
		if (en)
			wr(`BTC_OFF_CMD, 32'h100);
	endtask
	// wait for twelve quiet bus cycles
	task automatic idle;
		int i, q;
		q = 0;
		for (i = 0; i < 800 && q < 12; i++)
		begin
			@(posedge CORE_CLK);
			#1;
			q = (BUS_FRAME === 1'b0) ? q + 1 : 0;
		end
		if (q < 12)
			hang();
	endtask
	// hand one transaction to the sequencer and let it finish
	task automatic xf(input logic [1:0] k, input logic [31:0] a, input logic [3:0] c, input logic [7:0] n,
		input logic p, input logic [1:0] d);
		int i;
		@(posedge CORE_CLK);
		XFER_KIND <= k;
		XFER_ADDR <= a;
		XFER_CMD <= c;
		XFER_DWORDS <= n;
		XFER_PREF <= p;
		XFER_DST <= d;
		XFER_SRC <= (d == 2'h2) ? 2'h1 : 2'h2;
		XFER_VALID <= 1'b1;
		for (i = 0; i < 50 && XFER_TAKEN !== 1'b1; i++)
		begin
			@(posedge CORE_CLK);
			#1;
		end
		if (i == 50)
			hang();
		@(posedge CORE_CLK);
		XFER_VALID <= 1'b0;
		idle();
	endtask
	task automatic ts(input logic [13:0] v, input logic m, input logic [7:0] w, input logic [3:0] e);
		@(posedge CORE_CLK);
		{TS_KIND, TS_LOCKED, TS_ENQUEUING, TS_QUEUE_FULL, TS_DUP, TS_NOT_HEAD, TS_POSTED_AHEAD, TS_DISCARDING,
			TS_BUF_ROOM, TS_BOUNDARY, TS_WBUF_FULL, LOCK_ACTIVE, TGT_BUS_LOCKED} <= v;
		TS_MATCH <= m;
		TS_WANTED <= w;
		TS_REQ <= 1'b1;
		@(posedge CORE_CLK);
		TS_REQ <= 1'b0;
		#1;
		`CHK("ts_answer", e, {TS_RETRY, TS_DISCONNECT, TS_ABORT, TS_NO_DEVSEL})
	endtask
	// attempt log against expected count, address step and commands
	task automatic starts(input int n, input logic [31:0] a, input logic [31:0] s, input logic [3:0] c0,
		input logic [3:0] c1);
		`CHK("starts", n, aq.size())
		foreach (aq[i])
		begin
			`CHK("addr", a + i * s, aq[i])
			`CHK("cmd", i ? c1 : c0, cq[i])
		end
	endtask
	initial
	begin
		rst(16, 1'b0);
		rd(`BTC_OFF_CMD, 32'h0);
		rd(`BTC_OFF_EVDIS, 32'h0);
		rd(`BTC_OFF_STAT, 32'h0);
		rd(8'h10, 32'h0);
		`CHK("serr_n", 1'b1, UPSTREAM_SYSTEM_ERROR_N)
		wr(`BTC_OFF_EVDIS, 32'h24);
		rd(`BTC_OFF_EVDIS, 32'h24);
		// posted write retried twice, crossing between downstream ports
		rst(4, 1'b1);
		retries <= 8'h02;
		xf(K_PW, 32'h1000, `BTC_CMD_MW, 8'h01, 1'b0, 2'h2);
		starts(3, 32'h1000, 0, `BTC_CMD_MW, `BTC_CMD_MW);
		`CHK("free", 1'b1, fq[0])
		`CHK("port", 2'h2, BUS_PORT)
		// invalidate write disconnected after each dword
		rst(4, 1'b1);
		mode <= 2'h1;
		retries <= 8'h00;
		xf(K_PW, 32'h2000, `BTC_CMD_MWI, 8'h03, 1'b0, 2'h1);
		starts(3, 32'h2000, 4, `BTC_CMD_MWI, `BTC_CMD_MW);
		// posted write aborted by an upstream target
		rst(4, 1'b1);
		mode <= 2'h2;
		xf(K_PW, 32'h3000, `BTC_CMD_MW, 8'h01, 1'b0, 2'h0);
		`CHK("free", 1'b0, fq[0])
		`CHK("serr_pulses", 1, sc)
		rd(`BTC_OFF_STAT, 32'h5);
		wr(`BTC_OFF_STAT, 32'h5);
		rd(`BTC_OFF_STAT, 32'h0);
		// endless retry: limit reached with and without its disable bit
		for (r = 0; r < 4; r++)
		begin
			rst(4, 1'b1);
			wr(`BTC_OFF_EVDIS, r[0] ? (r[1] ? 32'h20 : 32'h4) : 32'h0);
			retries <= 8'hFF;
			mode <= 2'h0;
			repeat (r[1] ? 1 : 2) xf(r[1] ? K_DR : K_PW, 32'h4000, r[1] ? 4'h6 : `BTC_CMD_MW, 8'h01, 1'b0, 2'h1);
			`CHK("serr_pulses", r[0] ? 0 : (r[1] ? 1 : 2), sc)
		end
		// delayed reads: retried once, then each kind of ending
		foreach (drt[i])
		begin
			rst(4, 1'b1);
			retries <= 8'h01;
			mode <= drt[i][25:24];
			xf(K_DR, 32'h5000, 4'h6, drt[i][33:26], drt[i][34], 2'h1);
			`CHK("dr_ready", 1'b1, DR_READY)
			starts(2, 32'h5000, 0, 4'h6, 4'h6);
			if (drt[i][25:24] < 2'h2)
				`CHK("fetched", drt[i][15:8], DR_FETCHED)
			ts(14'h1000, 1'b1, drt[i][23:16], drt[i][7:4]);
			rd(`BTC_OFF_STAT, {28'h0, drt[i][3:0]});
		end
		// stored read never collected is dropped
		rst(4, 1'b1);
		retries <= 8'h00;
		mode <= 2'h0;
		xf(K_DR, 32'h6000, 4'h6, 8'h01, 1'b0, 2'h1);
		repeat (70) @(posedge CORE_CLK);
		#1;
		`CHK("dr_ready", 1'b0, DR_READY)
		// bridge-side answers, back to back
		// a stored matching read, so each delayed retry stands on its own reason
		rst(4, 1'b0);
		xf(K_DR, 32'h7000, 4'h6, 8'h01, 1'b0, 2'h1);
		foreach (tsr[i])
			ts(tsr[i][17:4], 1'b1, 8'h01, tsr[i][3:0]);
		// acceptance stretched past sixteen clocks, then a prompt one
		TS_ACCEPTING <= 1'b1;
		repeat (17) @(posedge CORE_CLK);
		ts(14'h1000, 1'b1, 8'h01, 4'h8);
		TS_ACCEPTING <= 1'b0;
		ts(14'h1000, 1'b1, 8'h01, 4'h4);
		report_and_stop();
	end
endmodule // btc_term_ctrl_tb
